// File: include/sst_alu_if.sv
`timescale 1ns/10ps
// ****************************************************************
// Operand and result bundle between sequencer and datapath
// ****************************************************************
interface sst_alu_if;
	logic [3:0] op;             // Operation code
	logic [2:0] bit_sel;        // Bit select for bit tests
	logic [7:0] acc;            // Accumulator operand
	logic [7:0] mem;            // Data memory operand
	logic [7:0] imm;            // Immediate operand
	logic [7:0] result;         // Value to write back
	logic       skip;           // Next instruction is to be skipped
	logic       wr_acc;         // Result goes to accumulator
	logic       wr_mem;         // Result goes to data memory
	logic       flags_upd;      // Flags below are to be loaded
	logic       carry;          // Carry, low on borrow
	logic       half_carry;     // Low nibble carry, low on borrow
	logic       zero;           // Result is zero
	logic       signed_range;   // Signed overflow

	// Sequencer side
	modport seq (output op, bit_sel, acc, mem, imm,
		input result, skip, wr_acc, wr_mem, flags_upd, carry, half_carry, zero, signed_range);
	// Datapath side
	modport alu (input op, bit_sel, acc, mem, imm,
		output result, skip, wr_acc, wr_mem, flags_upd, carry, half_carry, zero, signed_range);
endinterface

// File: include/sst_pkg.sv
// ****************************************************************
// Shared constants for the skip / subtract / swap / table executor
// ****************************************************************
package sst_pkg;

	// ****************************************************************
	// Register map (byte addresses of aligned 32-bit words)
	// ****************************************************************
	localparam int          APB_AW          = 8;        // Decoded address width
	localparam logic [7:0]  REG_EXEC        = 8'h00;    // Instruction issue
	localparam logic [7:0]  REG_ACC         = 8'h04;    // Accumulator
	localparam logic [7:0]  REG_STATUS      = 8'h08;    // Flags and sequencer state
	localparam logic [7:0]  REG_TBL_INDEX   = 8'h0c;    // Table index within page
	localparam logic [7:0]  REG_TBL_HIGH    = 8'h10;    // Table high byte, read only
	localparam logic [7:0]  REG_PC          = 8'h14;    // Instruction counter, read only
	localparam logic [7:0]  REG_CYCLES      = 8'h18;    // Instruction cycles spent
	localparam logic [7:0]  REG_MEM_ADDR    = 8'h1c;    // Data memory window address
	localparam logic [7:0]  REG_MEM_DATA    = 8'h20;    // Data memory window data
	localparam logic [7:0]  REG_PROG_ADDR   = 8'h24;    // Program memory window address
	localparam logic [7:0]  REG_PROG_DATA   = 8'h28;    // Program memory window data

	// ****************************************************************
	// Instruction word fields
	// ****************************************************************
	localparam int          OPC_LSB         = 0;        // Operation code
	localparam int          OPC_W           = 4;
	localparam int          BIT_LSB         = 4;        // Bit select
	localparam int          BIT_W           = 3;
	localparam int          OPER_LSB        = 8;        // Address or immediate byte
	localparam int          OPER_W          = 8;
	localparam int          EXEC_W          = 16;       // Stored instruction width

	// ****************************************************************
	// Operation codes
	// ****************************************************************
	localparam logic [3:0]  OP_NOP                      = 4'h0;
	localparam logic [3:0]  OP_INCR_SKIP_NULL           = 4'h1;
	localparam logic [3:0]  OP_INCR_SKIP_NULL_TO_ACC    = 4'h2;
	localparam logic [3:0]  OP_BIT_ONE_SKIP             = 4'h3;
	localparam logic [3:0]  OP_BIT_NULL_SKIP            = 4'h4;
	localparam logic [3:0]  OP_NULL_TEST_SKIP           = 4'h5;
	localparam logic [3:0]  OP_LOAD_NULL_TEST_SKIP      = 4'h6;
	localparam logic [3:0]  OP_SUB_MEM                  = 4'h7;
	localparam logic [3:0]  OP_ACC_MINUS_MEM_TO_MEM     = 4'h8;
	localparam logic [3:0]  OP_SUB_IMM                  = 4'h9;
	localparam logic [3:0]  OP_NIBBLE_EXCHANGE          = 4'ha;
	localparam logic [3:0]  OP_NIBBLE_EXCHANGE_TO_ACC   = 4'hb;
	localparam logic [3:0]  OP_TABLE_FETCH_CURRENT_PAGE = 4'hc;

	// ****************************************************************
	// Status bit positions, reset values and cycle costs
	// ****************************************************************
	localparam int          ST_CARRY        = 0;
	localparam int          ST_HALF_CARRY   = 1;
	localparam int          ST_ZERO         = 2;
	localparam int          ST_SIGNED_RANGE = 3;
	localparam int          ST_SKIP_PEND    = 4;
	localparam int          ST_DUMMY        = 5;
	localparam logic [7:0]  ACC_RST         = 8'h00;
	localparam logic [7:0]  BYTE_RST        = 8'h00;
	localparam logic [31:0] CYC_NORMAL      = 32'h0000_0001;  // Plain instruction
	localparam logic [31:0] CYC_SKIP        = 32'h0000_0002;  // Skip taken, dummy inserted
	localparam int          PAGE_W          = 8;              // Index bits within a page

endpackage

// File: src/sst_alu.sv
`timescale 1ns/10ps
// ****************************************************************
// Combinational datapath for the executed operations
// ****************************************************************
module sst_alu import sst_pkg::*; (
	// Operand and result bundle
	sst_alu_if.alu          a
);

	logic [8:0] diff;           // Full difference with borrow
	logic [4:0] diff_lo;        // Low nibble difference with borrow
	logic [7:0] sub_b;          // Subtrahend
	logic [7:0] incr;           // Incremented memory byte
	logic [7:0] swapped;        // Nibble-exchanged memory byte

	// Shared arithmetic
	always_comb begin
		sub_b   = (a.op == OP_SUB_IMM) ? a.imm : a.mem;
		diff    = {1'b0, a.acc} - {1'b0, sub_b};
		diff_lo = {1'b0, a.acc[3:0]} - {1'b0, sub_b[3:0]};
		incr    = a.mem + 8'h01;
		swapped = {a.mem[3:0], a.mem[7:4]};
	end

	// Flags of a subtraction; loaded only when flags_upd is set
	always_comb begin
		a.carry        = ~diff[8];
		a.half_carry   = ~diff_lo[4];
		a.zero         = (diff[7:0] == 8'h00);
		a.signed_range = (a.acc[7] ^ sub_b[7]) & (a.acc[7] ^ diff[7]);
	end

	// Per-operation result routing and skip decision
	always_comb begin
		a.result    = 8'h00;
		a.skip      = 1'b0;
		a.wr_acc    = 1'b0;
		a.wr_mem    = 1'b0;
		a.flags_upd = 1'b0;
		case (a.op)
			OP_INCR_SKIP_NULL: begin
				a.result = incr;
				a.wr_mem = 1'b1;
				a.skip   = (incr == 8'h00);
			end
			OP_INCR_SKIP_NULL_TO_ACC: begin
				a.result = incr;
				a.wr_acc = 1'b1;
				a.skip   = (incr == 8'h00);
			end
			OP_BIT_ONE_SKIP:   a.skip = a.mem[a.bit_sel];
			OP_BIT_NULL_SKIP:  a.skip = ~a.mem[a.bit_sel];
			OP_NULL_TEST_SKIP: a.skip = (a.mem == 8'h00);
			OP_LOAD_NULL_TEST_SKIP: begin
				a.result = a.mem;
				a.wr_acc = 1'b1;
				a.skip   = (a.mem == 8'h00);
			end
			OP_SUB_MEM, OP_SUB_IMM: begin
				a.result    = diff[7:0];
				a.wr_acc    = 1'b1;
				a.flags_upd = 1'b1;
			end
			OP_ACC_MINUS_MEM_TO_MEM: begin
				a.result    = diff[7:0];
				a.wr_mem    = 1'b1;
				a.flags_upd = 1'b1;
			end
			OP_NIBBLE_EXCHANGE: begin
				a.result = swapped;
				a.wr_mem = 1'b1;
			end
			OP_NIBBLE_EXCHANGE_TO_ACC: begin
				a.result = swapped;
				a.wr_acc = 1'b1;
			end
			default: begin
				a.result = 8'h00;
			end
		endcase
	end

endmodule // sst_alu

// File: src/sst_exec_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Increment memory byte, skip when zero
// - Increment into accumulator, skip when zero
// - Taken skip inserts one dummy cycle
// - Skip when selected bit is one
// - Skip when selected bit is zero
// - Skip when memory byte is zero
// - Copy byte to accumulator, skip when zero
// - Accumulator minus memory into accumulator
// - Accumulator minus memory into memory
// - Accumulator minus immediate into accumulator
// - Carry low on borrow, high otherwise
// - Swap memory nibbles in place, flags kept
// - Swapped byte into accumulator, memory kept
// - Table read: low to memory, high register
// - Skips, swaps, table read keep flags
module sst_exec_top import sst_pkg::*; #(
	parameter int DMEM_DEPTH = 256,     // Data memory bytes
	parameter int PC_W       = 12       // Program counter width, pages of 256 words
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_B,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	generate
		if (DMEM_DEPTH < 1 || DMEM_DEPTH > 256) begin : g_bad_dmem
			$error("DMEM_DEPTH must lie between 1 and 256");
		end
		if (PC_W <= PAGE_W || PC_W > 16) begin : g_bad_pc
			$error("PC_W must exceed the page index width and be at most 16");
		end
	endgenerate

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam int PMEM_DEPTH = 1 << PC_W;  // Program memory words

	logic [7:0]         dmem [DMEM_DEPTH];  // Data memory
	logic [15:0]        pmem [PMEM_DEPTH];  // Program memory

	logic [EXEC_W-1:0]  exec_q;             // Last issued instruction word
	logic [7:0]         acc_q;              // Accumulator
	logic               carry_q;            // Carry flag
	logic               half_carry_q;       // Half carry flag
	logic               zero_q;             // Zero flag
	logic               signed_range_q;     // Signed overflow flag
	logic               skip_pend_q;        // Next issued instruction is discarded
	logic               dummy_q;            // Dummy cycle after a taken skip
	logic [7:0]         table_index_q;      // Table index within current page
	logic [7:0]         table_high_byte_q;  // High byte of last table word
	logic [PC_W-1:0]    pc_q;               // Instruction counter
	logic [31:0]        cyc_q;              // Instruction cycles spent
	logic [7:0]         mem_addr_q;         // Data memory window address
	logic [PC_W-1:0]    prog_addr_q;        // Program memory window address
	logic [31:0]        prdata_q;           // Registered read data

	logic               access;             // APB access phase
	logic               wr_en;              // Write takes effect this edge
	logic               exec_req;           // Access to the issue register
	logic               go;                 // Instruction issued this edge
	logic               run;                // Issued instruction executes
	logic               annul;              // Issued instruction is discarded
	logic               is_table;           // Issued instruction is a table read
	logic [7:0]         oper;               // Operand byte of issued word
	logic [7:0]         exec_mem;           // Data byte addressed by operand
	logic [7:0]         win_mem;            // Data byte at window address
	logic [15:0]        table_word;         // Program word for the table read
	logic [PC_W-1:0]    table_addr;         // Current-page table address
	logic [31:0]        rd_d;               // Read mux
	logic               hit;                // Address is mapped

	sst_alu_if          alu_bus ();         // Datapath bundle

	// ****************************************************************
	// APB handshake
	// ****************************************************************
	// Access phase and issue register decode
	always_comb begin
		access   = PSEL & PENABLE;
		exec_req = access & PWRITE & (PADDR == REG_EXEC);
	end

	// The first issue after a taken skip waits one cycle: the dummy fetch
	assign PREADY  = ~(exec_req & dummy_q);
	assign PSLVERR = access & ~hit;
	assign PRDATA  = prdata_q;

	// Write strobe and issue decode
	always_comb begin
		wr_en    = access & PWRITE & PREADY & hit;
		go       = wr_en & (PADDR == REG_EXEC);
		annul    = go & skip_pend_q;
		run      = go & ~skip_pend_q;
		oper     = PWDATA[OPER_LSB +: OPER_W];
		is_table = (PWDATA[OPC_LSB +: OPC_W] == OP_TABLE_FETCH_CURRENT_PAGE);
	end

	// ****************************************************************
	// Memory reads
	// ****************************************************************
	// Out-of-range data addresses read as zero
	always_comb begin
		exec_mem   = (32'(oper) < DMEM_DEPTH) ? dmem[oper] : 8'h00;
		win_mem    = (32'(mem_addr_q) < DMEM_DEPTH) ? dmem[mem_addr_q] : 8'h00;
		table_addr = {pc_q[PC_W-1:PAGE_W], table_index_q};
		table_word = pmem[table_addr];
	end

	// ****************************************************************
	// Datapath
	// ****************************************************************
	// Operands come straight from the issue write
	always_comb begin
		alu_bus.op      = PWDATA[OPC_LSB +: OPC_W];
		alu_bus.bit_sel = PWDATA[BIT_LSB +: BIT_W];
		alu_bus.imm     = oper;
		alu_bus.mem     = exec_mem;
		alu_bus.acc     = acc_q;
	end

	sst_alu u_alu (
		.a (alu_bus.alu)
	);

	// ****************************************************************
	// Read mux
	// ****************************************************************
	// Unmapped addresses read zero and raise PSLVERR
	always_comb begin
		rd_d = 32'h0000_0000;
		hit  = 1'b1;
		case (PADDR)
			REG_EXEC:      rd_d = 32'(exec_q);
			REG_ACC:       rd_d = 32'(acc_q);
			REG_STATUS: begin
				rd_d[ST_CARRY]        = carry_q;
				rd_d[ST_HALF_CARRY]   = half_carry_q;
				rd_d[ST_ZERO]         = zero_q;
				rd_d[ST_SIGNED_RANGE] = signed_range_q;
				rd_d[ST_SKIP_PEND]    = skip_pend_q;
				rd_d[ST_DUMMY]        = dummy_q;
			end
			REG_TBL_INDEX: rd_d = 32'(table_index_q);
			REG_TBL_HIGH:  rd_d = 32'(table_high_byte_q);
			REG_PC:        rd_d = 32'(pc_q);
			REG_CYCLES:    rd_d = cyc_q;
			REG_MEM_ADDR:  rd_d = 32'(mem_addr_q);
			REG_MEM_DATA:  rd_d = 32'(win_mem);
			REG_PROG_ADDR: rd_d = 32'(prog_addr_q);
			REG_PROG_DATA: rd_d = 32'(pmem[prog_addr_q]);
			default:       hit  = 1'b0;
		endcase
	end

	// Read data captured in the setup cycle, held through access
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			prdata_q <= 32'h0000_0000;
		end else if (PSEL && !PENABLE) begin
			prdata_q <= rd_d;
		end
	end

	// ****************************************************************
	// Sequencer state
	// ****************************************************************
	// Issued word is kept for readback, discarded ones too
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			exec_q <= 16'h0000;
		end else if (go) begin
			exec_q <= PWDATA[EXEC_W-1:0];
		end
	end

	// Dummy cycle is owed after a taken skip and paid by stalling the next issue;
	// clearing on the stalled access keeps the stall to exactly one clock
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			dummy_q <= 1'b0;
		end else if (run && alu_bus.skip) begin
			dummy_q <= 1'b1;
		end else if (exec_req) begin
			dummy_q <= 1'b0;
		end
	end

	// Skip marks the next issued instruction for discard
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			skip_pend_q <= 1'b0;
		end else if (run && alu_bus.skip) begin
			skip_pend_q <= 1'b1;
		end else if (annul) begin
			skip_pend_q <= 1'b0;
		end
	end

	// Counter advances over executed and skipped words alike
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pc_q <= '0;
		end else if (go) begin
			pc_q <= pc_q + 1'b1;
		end
	end

	// A taken skip costs two cycles; the skipped word adds none
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cyc_q <= 32'h0000_0000;
		end else if (wr_en && PADDR == REG_CYCLES) begin
			cyc_q <= PWDATA;
		end else if (run) begin
			cyc_q <= cyc_q + (alu_bus.skip ? CYC_SKIP : CYC_NORMAL);
		end
	end

	// ****************************************************************
	// Architectural registers
	// ****************************************************************
	// Accumulator: software write or instruction result
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			acc_q <= ACC_RST;
		end else if (wr_en && PADDR == REG_ACC) begin
			acc_q <= PWDATA[7:0];
		end else if (run && alu_bus.wr_acc) begin
			acc_q <= alu_bus.result;
		end
	end

	// Flags: software write or a subtraction result; no other instruction loads them
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			carry_q        <= 1'b0;
			half_carry_q   <= 1'b0;
			zero_q         <= 1'b0;
			signed_range_q <= 1'b0;
		end else if (wr_en && PADDR == REG_STATUS) begin
			carry_q        <= PWDATA[ST_CARRY];
			half_carry_q   <= PWDATA[ST_HALF_CARRY];
			zero_q         <= PWDATA[ST_ZERO];
			signed_range_q <= PWDATA[ST_SIGNED_RANGE];
		end else if (run && alu_bus.flags_upd) begin
			carry_q        <= alu_bus.carry;
			half_carry_q   <= alu_bus.half_carry;
			zero_q         <= alu_bus.zero;
			signed_range_q <= alu_bus.signed_range;
		end
	end

	// Table index is software owned
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			table_index_q <= BYTE_RST;
		end else if (wr_en && PADDR == REG_TBL_INDEX) begin
			table_index_q <= PWDATA[7:0];
		end
	end

	// Table high byte from the fetched program word
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			table_high_byte_q <= BYTE_RST;
		end else if (run && is_table) begin
			table_high_byte_q <= table_word[15:8];
		end
	end

	// Window address registers
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			mem_addr_q  <= BYTE_RST;
			prog_addr_q <= '0;
		end else if (wr_en && PADDR == REG_MEM_ADDR) begin
			mem_addr_q  <= PWDATA[7:0];
		end else if (wr_en && PADDR == REG_PROG_ADDR) begin
			prog_addr_q <= PWDATA[PC_W-1:0];
		end
	end

	// ****************************************************************
	// Memory writes
	// ****************************************************************
	// Data memory: window write, instruction result or table low byte
	always_ff @(posedge CLK) begin
		if (wr_en && PADDR == REG_MEM_DATA && 32'(mem_addr_q) < DMEM_DEPTH) begin
			dmem[mem_addr_q] <= PWDATA[7:0];
		end else if (run && 32'(oper) < DMEM_DEPTH) begin
			if (alu_bus.wr_mem) begin
				dmem[oper] <= alu_bus.result;
			end else if (is_table) begin
				dmem[oper] <= table_word[7:0];
			end
		end
	end

	// Program memory is loaded through its window only
	always_ff @(posedge CLK) begin
		if (wr_en && PADDR == REG_PROG_DATA) begin
			pmem[prog_addr_q] <= PWDATA[15:0];
		end
	end

endmodule // sst_exec_top

// File: tb/skip_sub_swap_table_exec_tb.sv
`timescale 1ns/10ps
module skip_sub_swap_table_exec_tb import sst_pkg::*;;
	typedef struct packed {logic [7:0] acc; logic [7:0] mem; logic [3:0] fl; logic sk;} sst_exp_t;
	logic        CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, rdata, lfsr = 32'h7310;
	logic        PREADY, PSLVERR, err;
	int          fail_count = 0, total_checks = 0;
	always #5 CLK = ~CLK;
	sst_exec_top i_sst_exec_top (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
		.PRDATA, .PREADY, .PSLVERR);
	sst_mem_model i_sst_mem_model ();
	function automatic logic [7:0] rnd();
		for (int i = 0; i < 8; i++) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction
	// One APB transfer; entered just after a rising edge, answer taken at the ready edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		PSEL <= 1'b1; PWRITE <= wr; PADDR <= a; PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin @(posedge CLK); n++; end while (PREADY !== 1'b1 && n < 20);
		if (PREADY !== 1'b1) begin
			fail_count++;
			$display("[FAIL] pready exp 1 got %b", PREADY);
		end
		rdata = PRDATA; err = PSLVERR;
		PSEL <= 1'b0; PENABLE <= 1'b0;
		// Idle edge so the next call never reassigns the strobes in this time step
		@(posedge CLK);
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin fail_count++; $display("[FAIL] %s exp %h got %h", what, exp, got); end
	endtask
	// Expected state after one instruction
	function automatic sst_exp_t expect_of(logic [3:0] op, logic [2:0] b, logic [7:0] acc, m, imm,
		logic [3:0] fl, logic [15:0] pw);
		sst_exp_t r; logic [7:0] s; logic [8:0] d; logic [4:0] h;
		r = '{acc, m, fl, 1'b0};
		s = (op == OP_SUB_IMM) ? imm : m;
		d = {1'b0, acc} - {1'b0, s};
		h = {1'b0, acc[3:0]} - {1'b0, s[3:0]};
		case (op)
			OP_INCR_SKIP_NULL: begin r.mem = m + 8'h01; r.sk = r.mem == 8'h00; end
			OP_INCR_SKIP_NULL_TO_ACC: begin r.acc = m + 8'h01; r.sk = r.acc == 8'h00; end
			OP_BIT_ONE_SKIP: r.sk = m[b];
			OP_BIT_NULL_SKIP: r.sk = !m[b];
			OP_NULL_TEST_SKIP: r.sk = m == 8'h00;
			OP_LOAD_NULL_TEST_SKIP: begin r.acc = m; r.sk = m == 8'h00; end
			OP_SUB_MEM, OP_SUB_IMM: r.acc = d[7:0];
			OP_ACC_MINUS_MEM_TO_MEM: r.mem = d[7:0];
			OP_NIBBLE_EXCHANGE: r.mem = {m[3:0], m[7:4]};
			OP_NIBBLE_EXCHANGE_TO_ACC: r.acc = {m[3:0], m[7:4]};
			OP_TABLE_FETCH_CURRENT_PAGE: r.mem = pw[7:0];
			default: ;
		endcase
		if (op inside {OP_SUB_MEM, OP_SUB_IMM, OP_ACC_MINUS_MEM_TO_MEM})
			r.fl = {(acc[7] ^ s[7]) & (acc[7] ^ d[7]), d[7:0] == 8'h00, !h[4], !d[8]};
		return r;
	endfunction
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Watchdog well beyond the expected run length
	initial begin
		#400000;
		fail_count++;
		close_out();
	end
	initial begin
		logic [7:0] a, m, acc, idx; logic [3:0] op, fl; logic [2:0] b; logic [15:0] pw;
		logic [31:0] pc, cyc; sst_exp_t e;
		repeat (4) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		apb(1'b1, REG_PC, 32'h55);
		apb(1'b0, REG_PC, 32'h0);
		check("pc read only", 32'h0, rdata);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped err", 32'h1, 32'(err));
		check("unmapped data", 32'h0, rdata);
		// First all opcodes with all-ones then all-zero bytes, then random ones
		for (int k = 0; k < 60; k++) begin
			op = 4'(k < 26 ? k % 13 : rnd() % 13);
			a = rnd(); acc = rnd(); fl = 4'(rnd()); b = 3'(rnd()); idx = rnd(); pw = {rnd(), rnd()};
			i_sst_mem_model.dmem[a] = k < 13 ? 8'hff : k < 26 ? 8'h00 : rnd();
			m = i_sst_mem_model.dmem[a];
			apb(1'b1, REG_MEM_ADDR, {24'h0, a});
			apb(1'b1, REG_MEM_DATA, {24'h0, m});
			apb(1'b1, REG_ACC, {24'h0, acc});
			apb(1'b1, REG_STATUS, {28'h0, fl});
			apb(1'b1, REG_TBL_INDEX, {24'h0, idx});
			apb(1'b0, REG_PC, 32'h0);
			pc = rdata;
			apb(1'b1, REG_PROG_ADDR, {20'h0, pc[11:8], idx});
			apb(1'b1, REG_PROG_DATA, {16'h0, pw});
			apb(1'b0, REG_CYCLES, 32'h0);
			cyc = rdata;
			apb(1'b1, REG_EXEC, {16'h0, a, 1'b0, b, op});
			apb(1'b1, REG_EXEC, {16'h0, 8'h01, 4'h0, OP_SUB_IMM});
			e = expect_of(op, b, acc, m, a, fl, pw);
			if (!e.sk) e = expect_of(OP_SUB_IMM, 3'h0, e.acc, e.mem, 8'h01, e.fl, pw);
			apb(1'b0, REG_ACC, 32'h0);
			check("acc", {24'h0, e.acc}, rdata);
			apb(1'b0, REG_STATUS, 32'h0);
			check("flags", {28'h0, e.fl}, rdata & 32'hf);
			apb(1'b0, REG_MEM_DATA, 32'h0);
			check("mem", {24'h0, e.mem}, rdata);
			apb(1'b0, REG_CYCLES, 32'h0);
			check("cycles", 32'h2, rdata - cyc);
			apb(1'b0, REG_PC, 32'h0);
			check("pc", 32'h2, rdata - pc);
			apb(1'b0, REG_TBL_HIGH, 32'h0);
			if (op == OP_TABLE_FETCH_CURRENT_PAGE) check("high", {24'h0, pw[15:8]}, rdata);
		end
		close_out();
	end
endmodule // skip_sub_swap_table_exec_tb

// File: tb/sst_exec_monitor.sv
`timescale 1ns/10ps
// ****************************************************************
// Port checker for the executor
// ****************************************************************
module sst_exec_monitor import sst_pkg::*; (
	// Clock and reset
	input wire logic        CLK,
	input wire logic        RST_B,
	// APB
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	wire logic acc_ph = PSEL && PENABLE;    // Access phase
	chk_stall_exec_only: assert property (!PREADY |-> acc_ph && PWRITE && PADDR == REG_EXEC)
		else $error("stall outside an issue write");
	chk_stall_one_cycle: assert property (acc_ph && !PREADY |=> PREADY)
		else $error("stall longer than one cycle");
	chk_err_access_only: assert property (PSLVERR |-> acc_ph)
		else $error("error outside access phase");
	chk_err_unmapped: assert property (acc_ph && PADDR > REG_PROG_DATA |-> PSLVERR)
		else $error("unmapped access not refused");
	chk_err_mapped: assert property (acc_ph && PADDR <= REG_PROG_DATA && PADDR[1:0] == 2'h0
		|-> !PSLVERR) else $error("mapped access refused");
	chk_err_read_zero: assert property (acc_ph && !PWRITE && PSLVERR |-> PRDATA == 32'h0)
		else $error("refused read not zero");
	chk_rdata_held: assert property (acc_ph && $past(acc_ph) |-> $stable(PRDATA))
		else $error("read data moved in access");
	chk_acc_narrow: assert property (acc_ph && !PWRITE && PADDR == REG_ACC |-> PRDATA[31:8] == 24'h0)
		else $error("accumulator upper bits set");
	cov_stall: cover property (acc_ph && !PREADY);
	cov_refused: cover property (acc_ph && PSLVERR);
	cov_issue: cover property (acc_ph && PWRITE && PADDR == REG_EXEC && PREADY);
endmodule // sst_exec_monitor

bind sst_exec_top sst_exec_monitor i_sst_exec_monitor (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE,
	.PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);

// File: tb/sst_mem_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Image of the core data memory loaded into the executor
// ****************************************************************
module sst_mem_model;
	logic [7:0] dmem [256];     // Bytes as loaded
	// Unloaded bytes hold an inverted pattern, never a stale value
	initial foreach (dmem[i]) dmem[i] = ~8'(i);
endmodule // sst_mem_model
